// [hdl/prs_delay_counter.sv]
// Purpose: loadable down counter that flags expiry after load ticks
// Assumes: load is not zero
// Notes:   clear wins over start; start restarts a running count
`timescale 1ns/1ps
module prs_delay_counter #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic clock_in,
    input  wire logic rst_in,
    prs_timer_if.cnt  tmr
);
    import prs_pkg::*;

    logic [WIDTH-1:0] count_r;
    logic             busy_r;
    logic             done_r;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            count_r <= '0;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
        end else if (tmr.clear) begin
            count_r <= '0;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
        end else if (tmr.start) begin
            count_r <= tmr.load;
            busy_r  <= 1'b1;
            done_r  <= 1'b0;
        end else if (busy_r && tmr.tick) begin
            if (count_r == WIDTH'(1)) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
            end
            count_r <= count_r - WIDTH'(1);
        end
    end

    assign tmr.busy = busy_r;
    assign tmr.done = done_r;
endmodule

// [hdl/prs_sequencer.sv]
// Purpose: holds the core in reset through power-on, brown-out, power-up timer
//          and oscillator start-up, then releases it
// Assumes: clock_in is the internal rc oscillator clock; supply monitor and
//          oscillator inputs are asynchronous; configuration bits are static
// Notes:   core_reset_out is high while the core must stay in reset or stalled
// Summary of operation
// - hold reset until supply reaches operating level
// - falling supply never re-triggers power-on reset
// - 72 ms power-up delay, only after power-on/brown-out
// - power-up timer on rc clock holds reset
// - timer config bit one disables, zero enables
// - then 1024 oscillator input cycles hold reset
// - start-up delay: crystal modes, power-on or wake
// - brown-out enable bit one enables, zero disables
// - undervoltage longer than minimum duration resets
// - after reset wait above threshold, then timer
// - undervoltage during timer restarts full delay
`timescale 1ns/1ps
module prs_sequencer #(
    parameter int unsigned PUT_LEN = prs_pkg::PUT_CYCLES
) (
    input  wire logic                   clock_in,
    input  wire logic                   rst_in,
    input  wire logic                   supply_good_in,
    input  wire logic                   undervoltage_in,
    input  wire logic                   oscillator_input_in,
    input  wire logic                   power_up_timer_config_bit_in,
    input  wire logic                   brownout_enable_config_in,
    input  wire logic [2:0]             osc_mode_in,
    input  wire logic                   other_reset_in,
    input  wire logic                   sleep_wake_in,
    output logic                        core_reset_out,
    output prs_pkg::prs_state_type      stage_out,
    output prs_pkg::prs_cause_type      cause_out
);
    import prs_pkg::*;

    logic [1:0]    supply_sync_r;
    logic [1:0]    under_sync_r;
    logic [1:0]    osc_sync_r;
    logic          osc_prev_r;
    logic          power_seen_r;
    logic          brownout_trip_r;
    logic          core_reset_r;
    prs_state_type state_r;
    prs_state_type state_nxt;
    prs_cause_type cause_r;
    prs_cause_type cause_nxt;

    logic supply_good;
    logic under;
    logic osc_edge;
    logic crystal_mode;
    logic put_enabled;
    logic put_start;
    logic ost_start;
    logic hold_now;
    logic monitors_idle;

    prs_timer_if #(.WIDTH(PUT_WIDTH)) put_if ();
    prs_timer_if #(.WIDTH(OST_WIDTH)) ost_if ();
    prs_timer_if #(.WIDTH(BOD_WIDTH)) bod_if ();

    // two-stage synchronisers for the analog monitors and the oscillator input
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            supply_sync_r <= SYNC_RST;
            under_sync_r  <= SYNC_RST;
            osc_sync_r    <= SYNC_RST;
            osc_prev_r    <= 1'b0;
        end else begin
            supply_sync_r <= {supply_sync_r[0], supply_good_in};
            under_sync_r  <= {under_sync_r[0], undervoltage_in};
            osc_sync_r    <= {osc_sync_r[0], oscillator_input_in};
            osc_prev_r    <= osc_sync_r[1];
        end
    end

    assign supply_good = supply_sync_r[1];
    assign osc_edge    = osc_sync_r[1] & ~osc_prev_r;
    // undervoltage only counts when brown-out detection is enabled
    assign under       = under_sync_r[1] & brownout_enable_config_in;
    assign put_enabled = ~power_up_timer_config_bit_in;
    assign crystal_mode = (osc_mode_in == MODE_LOW_POWER_CRYSTAL) ||
                          (osc_mode_in == MODE_CRYSTAL) ||
                          (osc_mode_in == MODE_HIGH_SPEED_CRYSTAL);

    // latched once the supply first becomes good; only rst_in clears it
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            power_seen_r <= 1'b0;
        end else if (supply_good) begin
            power_seen_r <= 1'b1;
        end
    end

    // brown-out duration filter: count while undervoltage persists
    assign bod_if.start = under & ~bod_if.busy & ~bod_if.done;
    assign bod_if.clear = ~under;
    assign bod_if.tick  = 1'b1;
    assign bod_if.load  = BOD_LOAD;

    prs_delay_counter #(.WIDTH(BOD_WIDTH)) u_bod_filter (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .tmr      (bod_if.cnt)
    );

    // brown-out reset stands until the supply is back above threshold
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            brownout_trip_r <= 1'b0;
        end else if (bod_if.done) begin
            brownout_trip_r <= 1'b1;
        end else if (!under) begin
            brownout_trip_r <= 1'b0;
        end
    end

    assign monitors_idle = power_seen_r & ~under & ~brownout_trip_r;
    // an active reset condition that forces the sequence back to hold
    assign hold_now = ~power_seen_r | brownout_trip_r | other_reset_in;

    // power-up timer counts rc clock cycles
    assign put_if.tick  = 1'b1;
    assign put_if.load  = PUT_WIDTH'(PUT_LEN);
    assign put_if.start = put_start;
    assign put_if.clear = (state_r == PRS_PUT) && under;

    prs_delay_counter #(.WIDTH(PUT_WIDTH)) u_power_up_timer (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .tmr      (put_if.cnt)
    );

    // oscillator start-up timer counts oscillator input rising edges
    assign ost_if.tick  = osc_edge;
    assign ost_if.load  = OST_LOAD;
    assign ost_if.start = ost_start;
    assign ost_if.clear = hold_now;

    prs_delay_counter #(.WIDTH(OST_WIDTH)) u_oscillator_startup_timer (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .tmr      (ost_if.cnt)
    );

    // sequence control
    always_comb begin
        state_nxt = state_r;
        cause_nxt = cause_r;
        put_start = 1'b0;
        ost_start = 1'b0;
        case (state_r)
            PRS_HOLD: begin
                if (brownout_trip_r) begin
                    cause_nxt = (cause_r == CAUSE_POWER_ON) ? CAUSE_POWER_ON : CAUSE_BROWNOUT;
                end
                // an other reset seen while holding skips the power-up delay later
                if (other_reset_in) begin
                    cause_nxt = CAUSE_OTHER;
                end
                if (monitors_idle && !other_reset_in) begin
                    if (put_enabled && (cause_r != CAUSE_OTHER)) begin
                        state_nxt = PRS_PUT;
                        put_start = 1'b1;
                    end else if (crystal_mode && (cause_r == CAUSE_POWER_ON)) begin
                        state_nxt = PRS_OST;
                        ost_start = 1'b1;
                    end else begin
                        state_nxt = PRS_RUN;
                    end
                end
            end
            PRS_PUT: begin
                if (under) begin
                    // dip during the delay: back to brown-out hold, timer re-armed
                    state_nxt = PRS_HOLD;
                    cause_nxt = (cause_r == CAUSE_POWER_ON) ? CAUSE_POWER_ON : CAUSE_BROWNOUT;
                end else if (other_reset_in) begin
                    state_nxt = PRS_HOLD;
                    cause_nxt = CAUSE_OTHER;
                end else if (put_if.done) begin
                    if (crystal_mode && (cause_r == CAUSE_POWER_ON)) begin
                        state_nxt = PRS_OST;
                        ost_start = 1'b1;
                    end else begin
                        state_nxt = PRS_RUN;
                    end
                end
            end
            PRS_OST: begin
                if (hold_now) begin
                    state_nxt = PRS_HOLD;
                    if (other_reset_in) begin
                        cause_nxt = CAUSE_OTHER;
                    end
                end else if (ost_if.done) begin
                    state_nxt = PRS_RUN;
                end
            end
            PRS_RUN: begin
                if (brownout_trip_r) begin
                    state_nxt = PRS_HOLD;
                    cause_nxt = CAUSE_BROWNOUT;
                end else if (other_reset_in) begin
                    state_nxt = PRS_HOLD;
                    cause_nxt = CAUSE_OTHER;
                end else if (sleep_wake_in && crystal_mode) begin
                    state_nxt = PRS_OST;
                    cause_nxt = CAUSE_WAKE;
                    ost_start = 1'b1;
                end
            end
            default: begin
                state_nxt = PRS_HOLD;
            end
        endcase
        // a power-on reset that has not completed keeps its cause
        if (!power_seen_r) begin
            state_nxt = PRS_HOLD;
            cause_nxt = CAUSE_POWER_ON;
            put_start = 1'b0;
            ost_start = 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= PRS_HOLD;
            cause_r <= CAUSE_POWER_ON;
        end else begin
            state_r <= state_nxt;
            cause_r <= cause_nxt;
        end
    end

    // reset is released only from the run state
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            core_reset_r <= CORE_RESET_RST;
        end else begin
            core_reset_r <= (state_nxt != PRS_RUN);
        end
    end

    assign core_reset_out = core_reset_r;
    assign stage_out      = state_r;
    assign cause_out      = cause_r;

endmodule

// [inc/prs_pkg.sv]
// Purpose: shared constants and types for the power-up reset sequencer
// Assumes: clock_in runs at 10 MHz and is taken from the internal rc oscillator
// Notes:   times are kept in ns; rc clock cycle counts are derived from them
package prs_pkg;

    localparam int unsigned CLK_PERIOD_NS        = 100;
    // power-up timer nominal delay
    localparam int unsigned PUT_TIME_NS          = 72000000;
    localparam int unsigned PUT_CYCLES           = PUT_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned PUT_WIDTH            = 20;
    // shortest undervoltage that must trip a brown-out reset
    localparam int unsigned BROWNOUT_MIN_DURATION_NS = 100000;
    localparam int unsigned BROWNOUT_MIN_CYCLES  =
        (BROWNOUT_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BOD_WIDTH            = 12;
    // oscillator start-up length in oscillator_input cycles
    localparam int unsigned OST_CYCLES           = 1024;
    localparam int unsigned OST_WIDTH            = 11;

    localparam logic [BOD_WIDTH-1:0] BOD_LOAD    = BOD_WIDTH'(BROWNOUT_MIN_CYCLES);
    localparam logic [OST_WIDTH-1:0] OST_LOAD    = OST_WIDTH'(OST_CYCLES);

    // oscillator mode encoding of the configuration word
    localparam logic [2:0] MODE_LOW_POWER_CRYSTAL  = 3'h0;
    localparam logic [2:0] MODE_CRYSTAL            = 3'h1;
    localparam logic [2:0] MODE_HIGH_SPEED_CRYSTAL = 3'h2;

    // values after reset
    localparam logic       CORE_RESET_RST        = 1'h1;
    localparam logic [1:0] SYNC_RST              = 2'h0;

    typedef enum logic [1:0] {
        PRS_HOLD = 2'b00,
        PRS_PUT  = 2'b01,
        PRS_OST  = 2'b10,
        PRS_RUN  = 2'b11
    } prs_state_type;

    typedef enum logic [1:0] {
        CAUSE_POWER_ON = 2'b00,
        CAUSE_BROWNOUT = 2'b01,
        CAUSE_OTHER    = 2'b10,
        CAUSE_WAKE     = 2'b11
    } prs_cause_type;

endpackage

// [inc/prs_timer_if.sv]
// Purpose: control and status bundle of one delay counter
// Assumes: one clock domain
// Notes:   load is sampled on start; done stays high until the next start or clear
`timescale 1ns/1ps
interface prs_timer_if #(parameter int unsigned WIDTH = 8);
    logic             start;
    logic             clear;
    logic             tick;
    logic [WIDTH-1:0] load;
    logic             busy;
    logic             done;

    modport ctrl (output start, output clear, output tick, output load, input busy, input done);
    modport cnt  (input start, input clear, input tick, input load, output busy, output done);
endinterface

// [tb/prs_osc_model.sv]
// Purpose: free-running crystal on the oscillator input
// Assumes: period of 800 ns, well below a quarter of clock_in
// Notes:   starts low and runs for the whole run
`timescale 1ns/1ps
module prs_osc_model (
    output logic osc_out
);
    initial begin
        osc_out = 1'b0;
        forever #400 osc_out = !osc_out;
    end
endmodule

// [tb/prs_seq_monitor.sv]
// Purpose: port-level checks of the reset sequencer
// Assumes: PUT_LEN matches the bound instance
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module prs_seq_monitor #(
    parameter int unsigned PUT_LEN = 20
) (
    input  wire logic                   clock_in,
    input  wire logic                   rst_in,
    input  wire logic                   supply_good_in,
    input  wire logic                   undervoltage_in,
    input  wire logic                   oscillator_input_in,
    input  wire logic                   power_up_timer_config_bit_in,
    input  wire logic                   brownout_enable_config_in,
    input  wire logic [2:0]             osc_mode_in,
    input  wire logic                   other_reset_in,
    input  wire logic                   sleep_wake_in,
    input  wire logic                   core_reset_out,
    input  wire prs_pkg::prs_state_type stage_out,
    input  wire prs_pkg::prs_cause_type cause_out
);
    import prs_pkg::*;
    logic [31:0] put_cnt_r;
    logic [11:0] osc_cnt_r;
    logic [11:0] uv_cnt_r;
    logic        osc_q_r;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            put_cnt_r <= '0;
            osc_cnt_r <= '0;
            uv_cnt_r  <= '0;
            osc_q_r   <= 1'b0;
        end else begin
            osc_q_r   <= oscillator_input_in;
            put_cnt_r <= (stage_out == PRS_PUT) ? put_cnt_r + 32'h1 : 32'h0;
            osc_cnt_r <= (stage_out != PRS_OST) ? 12'h0 : osc_cnt_r + 12'(oscillator_input_in && !osc_q_r);
            uv_cnt_r  <= !(undervoltage_in && brownout_enable_config_in) ? 12'h0 :
                         (uv_cnt_r == 12'hFFF) ? uv_cnt_r : uv_cnt_r + 12'h1;
        end
    end
    core_release_a: assert property (core_reset_out == (stage_out != PRS_RUN))
        else $error("core reset disagrees with stage");
    no_supply_a: assert property ((!supply_good_in)[*4] ##0
        (stage_out == PRS_HOLD && cause_out == CAUSE_POWER_ON) |=> stage_out == PRS_HOLD)
        else $error("left hold without supply");
    fall_ignore_a: assert property ((stage_out == PRS_RUN && !supply_good_in && !other_reset_in
        && !sleep_wake_in && !undervoltage_in) |=> stage_out == PRS_RUN) else $error("falling supply caused reset");
    put_long_a: assert property (stage_out == PRS_PUT |-> put_cnt_r <= PUT_LEN + 1)
        else $error("power-up delay too long");
    put_short_a: assert property ((stage_out == PRS_PUT && put_cnt_r + 2 < PUT_LEN)
        |=> stage_out inside {PRS_PUT, PRS_HOLD}) else $error("power-up delay too short");
    other_noput_a: assert property (cause_out == CAUSE_OTHER |-> stage_out != PRS_PUT)
        else $error("power-up delay after other reset");
    other_hold_a: assert property (other_reset_in |=> stage_out == PRS_HOLD && cause_out == CAUSE_OTHER)
        else $error("other reset not held");
    cfg_off_a: assert property (power_up_timer_config_bit_in |-> stage_out != PRS_PUT)
        else $error("disabled power-up delay ran");
    ost_len_a: assert property ((stage_out == PRS_OST ##1 stage_out == PRS_RUN)
        |-> osc_cnt_r inside {[1022:1026]}) else $error("start-up count wrong");
    ost_mode_a: assert property (stage_out == PRS_OST |-> osc_mode_in <= 3'h2)
        else $error("start-up delay in non-crystal mode");
    wake_ost_a: assert property ((sleep_wake_in && stage_out == PRS_RUN && osc_mode_in <= 3'h2
        && !other_reset_in && !undervoltage_in) |=> stage_out == PRS_OST && cause_out == CAUSE_WAKE)
        else $error("wake without start-up");
    bod_trip_a: assert property (uv_cnt_r > BROWNOUT_MIN_CYCLES + 5 |-> stage_out == PRS_HOLD)
        else $error("long undervoltage not reset");
    bod_off_a: assert property ((!brownout_enable_config_in && stage_out == PRS_RUN && !other_reset_in
        && !sleep_wake_in) |=> stage_out == PRS_RUN) else $error("reset with brown-out disabled");
    put_rearm_a: assert property ((stage_out == PRS_PUT && undervoltage_in && brownout_enable_config_in)[*3]
        |-> ##[1:2] stage_out == PRS_HOLD) else $error("dip in power-up delay ignored");
endmodule

// [tb/tb_prs_sequencer.sv]
// Purpose: directed scenarios for the reset sequencer
// Assumes: oscillator model period is 8 clock cycles
// Notes:   short power-up delay via PUT_LEN
`timescale 1ns/1ps
module tb_prs_sequencer;
    import prs_pkg::*;
    localparam int unsigned PL = 20;
    logic                  clock_in;
    logic                  rst_in;
    logic                  sup;
    logic                  uv;
    logic                  osc;
    logic                  pwr_off;
    logic                  bod_en;
    logic [2:0]            mode;
    logic                  other;
    logic                  wake;
    logic                  core_reset;
    prs_state_type         stage;
    prs_cause_type         cause;
    int                    fail_count = 0;
    int                    comparisons = 0;
    int                    cyc = 0;
    int                    n;
    logic                  seen_put;
    logic                  seen_ost;
    prs_osc_model prs_osc_model_i (.osc_out(osc));
    prs_sequencer #(.PUT_LEN(PL)) prs_sequencer_i (
        .clock_in(clock_in), .rst_in(rst_in), .supply_good_in(sup), .undervoltage_in(uv),
        .oscillator_input_in(osc), .power_up_timer_config_bit_in(pwr_off),
        .brownout_enable_config_in(bod_en), .osc_mode_in(mode), .other_reset_in(other),
        .sleep_wake_in(wake), .core_reset_out(core_reset), .stage_out(stage), .cause_out(cause));
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = !clock_in;
    end
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            $display("unexpected at %0t: run hung", $time);
            test_done();
        end
    end
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(negedge clock_in);
    endtask
    task automatic restart(input logic [2:0] m, input logic p_off, input logic b_en, input int hold);
        rst_in = 1'b1;
        {sup, uv, other, wake} = 4'h0;
        {mode, pwr_off, bod_en} = {m, p_off, b_en};
        step(hold);
        rst_in = 1'b0;
        step(30);
        chk(core_reset === 1'b1 && stage === PRS_HOLD, "released before supply");
    endtask
    task automatic wait_rel(input int maxc);
        {seen_put, seen_ost} = 2'b00;
        n = 0;
        while (core_reset !== 1'b0 && n < maxc) begin
            step(1);
            n++;
            if (stage === PRS_PUT) seen_put = 1'b1;
            if (stage === PRS_OST) seen_ost = 1'b1;
        end
        chk(core_reset === 1'b0 && stage === PRS_RUN, "reset not released");
    endtask
    task automatic s_power_on();
        logic [2:0] modes [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        logic       xtal;
        foreach (modes[i]) begin
            xtal = modes[i] <= 3'h2;
            restart(modes[i], 1'b0, 1'b0, 3);
            sup = 1'b1;
            wait_rel(9000);
            chk(seen_put === 1'b1 && seen_ost === xtal, "stage order");
            chk(n >= PL + (xtal ? 8150 : 0) && cause === CAUSE_POWER_ON, "release too early");
        end
    endtask
    task automatic s_cfg_off();
        restart(3'h4, 1'b1, 1'b0, 3);
        sup = 1'b1;
        wait_rel(50);
        chk(seen_put === 1'b0 && n < 10, "disabled timer ran");
        uv = 1'b1;
        step(1100);
        chk(stage === PRS_RUN, "brown-out while disabled");
        uv = 1'b0;
    endtask
    task automatic s_run_events();
        restart(3'h4, 1'b0, 1'b1, 3);
        sup = 1'b1;
        wait_rel(100);
        sup = 1'b0;
        step(20);
        chk(stage === PRS_RUN, "reset on falling supply");
        wake = 1'b1;
        step(1);
        wake = 1'b0;
        step(3);
        chk(stage === PRS_RUN, "start-up in non-crystal wake");
        uv = 1'b1;
        step(500);
        uv = 1'b0;
        step(5);
        chk(stage === PRS_RUN, "short dip reset");
        uv = 1'b1;
        step(1100);
        chk(stage === PRS_HOLD && cause === CAUSE_BROWNOUT && core_reset === 1'b1, "no brown-out");
        uv = 1'b0;
        wait_rel(100);
        chk(seen_put === 1'b1 && n >= PL, "no delay after brown-out");
        other = 1'b1;
        step(3);
        chk(stage === PRS_HOLD && cause === CAUSE_OTHER, "other reset not held");
        other = 1'b0;
        wait_rel(20);
        chk(seen_put === 1'b0, "delay after other reset");
    endtask
    task automatic s_rearm_wake();
        restart(3'h1, 1'b0, 1'b1, 3);
        sup = 1'b1;
        step(14);
        chk(stage === PRS_PUT, "not in power-up delay");
        uv = 1'b1;
        step(5);
        chk(stage === PRS_HOLD && core_reset === 1'b1, "dip ignored in delay");
        uv = 1'b0;
        wait_rel(9000);
        chk(seen_put === 1'b1 && seen_ost === 1'b1 && n >= PL + 8150, "delay not restarted");
        wake = 1'b1;
        step(1);
        wake = 1'b0;
        step(2);
        chk(stage === PRS_OST && cause === CAUSE_WAKE && core_reset === 1'b1, "wake start-up");
        wait_rel(9000);
        chk(n >= 8150, "wake start-up short");
    endtask
    initial begin
        rst_in = 1'b1;
        {sup, uv, other, wake, pwr_off, bod_en} = 6'h0;
        mode = 3'h4;
        step(12);
        s_power_on();
        s_cfg_off();
        s_run_events();
        s_rearm_wake();
        test_done();
    end
endmodule
bind prs_sequencer prs_seq_monitor #(.PUT_LEN(PUT_LEN)) prs_seq_monitor_i (
    .clock_in(clock_in), .rst_in(rst_in), .supply_good_in(supply_good_in), .undervoltage_in(undervoltage_in),
    .oscillator_input_in(oscillator_input_in), .power_up_timer_config_bit_in(power_up_timer_config_bit_in),
    .brownout_enable_config_in(brownout_enable_config_in), .osc_mode_in(osc_mode_in),
    .other_reset_in(other_reset_in), .sleep_wake_in(sleep_wake_in), .core_reset_out(core_reset_out),
    .stage_out(stage_out), .cause_out(cause_out));
